// >>> pkg/pio_pkg.sv
// Shared offsets, field positions, reset values and carrier types of the parallel I/O block.
`default_nettype none

package pio_pkg;

   // Byte offsets inside the port block region.
   localparam logic [7:0] PORT_A_OFF    = 8'h00;
   localparam logic [7:0] PORT_B_OFF    = 8'h01;
   localparam logic [7:0] PORT_C_OFF    = 8'h02;
   localparam logic [7:0] PORT_CFG_OFF  = 8'h03;
   localparam logic [7:0] CTR0_OFF      = 8'h04;
   localparam logic [7:0] CTR1_OFF      = 8'h05;
   localparam logic [7:0] CTR2_OFF      = 8'h06;
   localparam logic [7:0] CTR_CTRL_OFF  = 8'h07;

   // Byte offsets inside the board control region.
   localparam logic [7:0] IRQ_REG_OFF   = 8'h4C;
   localparam logic [7:0] USER_REG_OFF  = 8'h50;

   // Interrupt register fields.
   localparam int IRQ_EN_BIT       = 0;
   localparam int IRQ_POL_BIT      = 1;
   localparam int IRQ_STAT_BIT     = 2;
   localparam int HOST_IRQ_EN_BIT  = 6;

   // User control register field.
   localparam int OSC_SEL_BIT      = 2;

   // Configuration byte fields; a set direction bit means input.
   localparam int CFG_FLAG_BIT     = 7;
   localparam int CFG_A_BIT        = 4;
   localparam int CFG_UC_BIT       = 3;
   localparam int CFG_B_BIT        = 1;
   localparam int CFG_LC_BIT       = 0;
   localparam logic [7:0] CFG_ZERO_MASK = 8'h64;

   // Values after reset.
   localparam logic [7:0]  CFG_RESET       = 8'h9B;
   localparam logic [7:0]  PORT_OUT_RESET  = 8'h00;
   localparam logic [31:0] IRQ_REG_RESET   = 32'h00000041;
   localparam logic [31:0] USER_REG_RESET  = 32'h00000002;
   localparam logic [31:0] IRQ_RO_MASK     = 32'h00000004;
   localparam logic        HOST_IRQ_RESET  = 1'h1;

   // One host I/O access, offered for a single clock cycle.
   typedef struct packed {
      logic        sel_ctrl;
      logic        sel_port;
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } pio_host_req_t;

   // The twenty-four port lines, grouped by port.
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] c;
   } pio_lines_t;

   // Write strobes and data towards the counter logic.
   typedef struct packed {
      logic [2:0] load;
      logic       ctrl_wr;
      logic [7:0] data;
   } pio_ctr_wr_t;

endpackage

`default_nettype wire

// >>> verilog/pio_sync3.sv
// Three-stage input synchroniser that accepts a bit once its last two stages agree.
`timescale 1ns/1ps
`default_nettype none

module pio_sync3 #(
   parameter int WIDTH = 25
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] ff1_reg;
   logic [WIDTH-1:0] ff2_reg;
   logic [WIDTH-1:0] ff3_reg;
   logic [WIDTH-1:0] q_reg;
   logic [WIDTH-1:0] q_next;
   wire  logic [WIDTH-1:0] agree;

   // The first stage may be metastable, so only the second stage looks at it.
   assign agree  = ~(ff2_reg ^ ff3_reg);
   assign q_next = (agree & ff3_reg) | (~agree & q_reg);
   assign q      = q_reg;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ff1_reg <= '0;
         ff2_reg <= '0;
         ff3_reg <= '0;
         q_reg   <= '0;
      end
      else
      begin
         ff1_reg <= d;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
         q_reg   <= q_next;
      end
   end

endmodule

`default_nettype wire

// >>> verilog/pio_regs.sv
// Register block of a 24-line parallel I/O board with interrupt control, and clock-select control on the counter variant only.
`timescale 1ns/1ps
`default_nettype none

module pio_regs #(
   parameter bit HAS_COUNTER = 1'b1
) (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire pio_pkg::pio_host_req_t host_req,
   output var  logic [31:0]            host_rdata,
   output var  logic                   host_rvalid,
   input  wire pio_pkg::pio_lines_t    line_in,
   output var  pio_pkg::pio_lines_t    line_out,
   output var  pio_pkg::pio_lines_t    line_oe,
   input  wire logic                   irq_source_in,
   output var  logic                   host_irq,
   output var  pio_pkg::pio_ctr_wr_t   ctr_wr,
   output var  logic [2:0]             ctr_rd,
   input  wire logic [7:0]             ctr_rdata,
   output var  logic                   osc_freq_select
);

   // Port output latches and direction configuration.
   logic [7:0]  out_a_reg;
   logic [7:0]  out_b_reg;
   logic [7:0]  out_c_reg;
   logic [7:0]  cfg_reg;

   // Board control words.
   logic [31:0] irq_reg;
   logic [31:0] user_reg;
   logic        host_irq_reg;

   // Host read answer and counter strobes.
   logic [31:0] rdata_reg;
   logic        rvalid_reg;
   pio_pkg::pio_ctr_wr_t ctr_wr_reg;

   // Synchronised pins.
   wire logic [24:0]         sync_q;
   wire pio_pkg::pio_lines_t pins;
   wire logic                irq_active;

   // Picks, bit by bit, the driven value where a line is an output and the pin otherwise.
   function automatic logic [7:0] pio_pick(
      input logic [7:0] oe,
      input logic [7:0] drive,
      input logic [7:0] pin
   );
      return (oe & drive) | (~oe & pin);
   endfunction

   // Compares a host offset with one location of the map.
   function automatic logic pio_at(
      input logic [7:0] addr,
      input logic [7:0] off
   );
      return addr == off;
   endfunction

   pio_sync3 #(
      .WIDTH (25)
   ) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     ({irq_source_in, line_in}),
      .q     (sync_q)
   );

   assign pins       = sync_q[23:0];
   assign irq_active = sync_q[24];

   // Region selects; a control-region access wins if both are raised.
   wire logic ctrl_sel;
   wire logic port_sel;
   wire logic ctr_ok;
   assign ctrl_sel = host_req.sel_ctrl;
   assign port_sel = host_req.sel_port & ~host_req.sel_ctrl;
   assign ctr_ok   = HAS_COUNTER;

   // Write decode of the port block.
   wire logic wr_port;
   wire logic wr_a;
   wire logic wr_b;
   wire logic wr_c;
   wire logic wr_cfg;
   wire logic cfg_legal;
   assign wr_port   = host_req.wr & port_sel;
   assign wr_a      = wr_port & pio_at(host_req.addr, pio_pkg::PORT_A_OFF);
   assign wr_b      = wr_port & pio_at(host_req.addr, pio_pkg::PORT_B_OFF);
   assign wr_c      = wr_port & pio_at(host_req.addr, pio_pkg::PORT_C_OFF);
   assign wr_cfg    = wr_port & pio_at(host_req.addr, pio_pkg::PORT_CFG_OFF);

   // Only the plain input/output mode exists here, so any other byte is ignored.
   assign cfg_legal = host_req.wdata[pio_pkg::CFG_FLAG_BIT]
                      & ((host_req.wdata[7:0] & pio_pkg::CFG_ZERO_MASK) == 8'h00);

   // Counter locations, present only on the counter variant.
   wire logic [2:0] wr_ctr;
   wire logic       wr_ctr_ctrl;
   wire logic [2:0] rd_ctr;
   assign wr_ctr[0]   = wr_port & ctr_ok & pio_at(host_req.addr, pio_pkg::CTR0_OFF);
   assign wr_ctr[1]   = wr_port & ctr_ok & pio_at(host_req.addr, pio_pkg::CTR1_OFF);
   assign wr_ctr[2]   = wr_port & ctr_ok & pio_at(host_req.addr, pio_pkg::CTR2_OFF);
   assign wr_ctr_ctrl = wr_port & ctr_ok
                        & pio_at(host_req.addr, pio_pkg::CTR_CTRL_OFF);
   assign rd_ctr[0]   = host_req.rd & port_sel & ctr_ok
                        & pio_at(host_req.addr, pio_pkg::CTR0_OFF);
   assign rd_ctr[1]   = host_req.rd & port_sel & ctr_ok
                        & pio_at(host_req.addr, pio_pkg::CTR1_OFF);
   assign rd_ctr[2]   = host_req.rd & port_sel & ctr_ok
                        & pio_at(host_req.addr, pio_pkg::CTR2_OFF);
   assign ctr_rd      = rd_ctr;

   // Board control region decode.
   wire logic wr_irq;
   wire logic wr_user;
   assign wr_irq  = host_req.wr & ctrl_sel & pio_at(host_req.addr, pio_pkg::IRQ_REG_OFF);
   assign wr_user = host_req.wr & ctrl_sel & ctr_ok
                    & pio_at(host_req.addr, pio_pkg::USER_REG_OFF);

   // Direction masks, high where the device drives a line.
   wire logic [7:0] oe_a;
   wire logic [7:0] oe_b;
   wire logic [7:0] oe_c;
   assign oe_a = {8{~cfg_reg[pio_pkg::CFG_A_BIT]}};
   assign oe_b = {8{~cfg_reg[pio_pkg::CFG_B_BIT]}};
   assign oe_c = {{4{~cfg_reg[pio_pkg::CFG_UC_BIT]}},
                  {4{~cfg_reg[pio_pkg::CFG_LC_BIT]}}};

   // Output latches drive the pins whatever the direction was when they were written.
   assign line_out.a = out_a_reg;
   assign line_out.b = out_b_reg;
   assign line_out.c = out_c_reg;
   assign line_oe.a  = oe_a;
   assign line_oe.b  = oe_b;
   assign line_oe.c  = oe_c;

   // Port read values mix latch and live pins per direction.
   wire logic [7:0] rd_a;
   wire logic [7:0] rd_b;
   wire logic [7:0] rd_c;
   assign rd_a = pio_pick(oe_a, out_a_reg, pins.a);
   assign rd_b = pio_pick(oe_b, out_b_reg, pins.b);
   assign rd_c = pio_pick(oe_c, out_c_reg, pins.c);

   // Port region read mux; bytes sit in the low lane and unmapped offsets read zero.
   wire logic [7:0] port_rd_byte;
   assign port_rd_byte =
      pio_at(host_req.addr, pio_pkg::PORT_A_OFF)   ? rd_a      :
      pio_at(host_req.addr, pio_pkg::PORT_B_OFF)   ? rd_b      :
      pio_at(host_req.addr, pio_pkg::PORT_C_OFF)   ? rd_c      :
      pio_at(host_req.addr, pio_pkg::PORT_CFG_OFF) ? cfg_reg   :
      (rd_ctr != 3'h0)                             ? ctr_rdata : 8'h00;

   // The status bit is never stored; it shows the live interrupt condition.
   wire logic [31:0] irq_rd_word;
   assign irq_rd_word = (irq_reg & ~pio_pkg::IRQ_RO_MASK)
                        | ({31'h0, irq_active} << pio_pkg::IRQ_STAT_BIT);

   wire logic [31:0] ctrl_rd_word;
   assign ctrl_rd_word =
      pio_at(host_req.addr, pio_pkg::IRQ_REG_OFF)            ? irq_rd_word :
      (ctr_ok & pio_at(host_req.addr, pio_pkg::USER_REG_OFF)) ? user_reg    : 32'h00000000;

   wire logic [31:0] rd_word;
   assign rd_word = ctrl_sel ? ctrl_rd_word :
                    port_sel ? {24'h000000, port_rd_byte} : 32'h00000000;

   // Host interrupt level; the inactive level is the inverse of the chosen polarity.
   wire logic irq_fire;
   wire logic host_irq_next;
   assign irq_fire      = irq_active
                          & irq_reg[pio_pkg::IRQ_EN_BIT]
                          & irq_reg[pio_pkg::HOST_IRQ_EN_BIT];
   assign host_irq_next = irq_fire ? irq_reg[pio_pkg::IRQ_POL_BIT]
                                   : ~irq_reg[pio_pkg::IRQ_POL_BIT];

   assign host_irq        = host_irq_reg;
   assign osc_freq_select = user_reg[pio_pkg::OSC_SEL_BIT];
   assign host_rdata      = rdata_reg;
   assign host_rvalid     = rvalid_reg;
   assign ctr_wr          = ctr_wr_reg;

   // Port output latches; a write lands whatever the current direction.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         out_a_reg <= pio_pkg::PORT_OUT_RESET;
         out_b_reg <= pio_pkg::PORT_OUT_RESET;
         out_c_reg <= pio_pkg::PORT_OUT_RESET;
      end
      else
      begin
         if (wr_a)
            out_a_reg <= host_req.wdata[7:0];
         if (wr_b)
            out_b_reg <= host_req.wdata[7:0];
         if (wr_c)
            out_c_reg <= host_req.wdata[7:0];
      end
   end

   // Direction configuration; reset leaves every line an input.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         cfg_reg <= pio_pkg::CFG_RESET;
      else if (wr_cfg & cfg_legal)
         cfg_reg <= host_req.wdata[7:0];
   end

   // Board control words keep every writable bit, since other bits have other uses.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         irq_reg  <= pio_pkg::IRQ_REG_RESET;
         user_reg <= pio_pkg::USER_REG_RESET;
      end
      else
      begin
         if (wr_irq)
            irq_reg <= host_req.wdata & ~pio_pkg::IRQ_RO_MASK;
         if (wr_user)
            user_reg <= host_req.wdata;
      end
   end

   // Host interrupt pin follows its cause one cycle later.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         host_irq_reg <= pio_pkg::HOST_IRQ_RESET;
      else
         host_irq_reg <= host_irq_next;
   end

   // Read answer one cycle after the request; data holds until the next read.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rdata_reg  <= 32'h00000000;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rvalid_reg <= host_req.rd;
         if (host_req.rd)
            rdata_reg <= rd_word;
      end
   end

   // Counter load and control strobes are registered so the data goes out with them.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         ctr_wr_reg <= '0;
      else
      begin
         ctr_wr_reg.load    <= wr_ctr;
         ctr_wr_reg.ctrl_wr <= wr_ctr_ctrl;
         if ((wr_ctr != 3'h0) | wr_ctr_ctrl)
            ctr_wr_reg.data <= host_req.wdata[7:0];
      end
   end

endmodule

`default_nettype wire

// >>> testbench/pio_regs_chk.sv
// Port-level assertion checker for the parallel I/O register block.
`timescale 1ns/1ps
`default_nettype none

module pio_regs_chk #(
   parameter bit HAS_COUNTER = 1'b1
) (
   input wire logic                   clock,
   input wire logic                   rst_n,
   input wire pio_pkg::pio_host_req_t host_req,
   input wire logic [31:0]            host_rdata,
   input wire logic                   host_rvalid,
   input wire pio_pkg::pio_lines_t    line_in,
   input wire pio_pkg::pio_lines_t    line_out,
   input wire pio_pkg::pio_lines_t    line_oe,
   input wire logic                   irq_source_in,
   input wire logic                   host_irq,
   input wire pio_pkg::pio_ctr_wr_t   ctr_wr,
   input wire logic [2:0]             ctr_rd,
   input wire logic [7:0]             ctr_rdata,
   input wire logic                   osc_freq_select
);
   wire        sel_p  = host_req.sel_port && !host_req.sel_ctrl;
   wire        wr_p   = sel_p && host_req.wr;
   wire        rd_p   = sel_p && host_req.rd;
   wire        wr_c   = host_req.sel_ctrl && host_req.wr;
   wire        rd_any = host_req.rd && (host_req.sel_port || host_req.sel_ctrl);
   wire        cfg_ok = host_req.wdata[7] && host_req.wdata[6:5] == 2'h0 && !host_req.wdata[2];
   wire [23:0] oe_new = {{8{!host_req.wdata[4]}}, {8{!host_req.wdata[1]}},
                         {4{!host_req.wdata[3]}}, {4{!host_req.wdata[0]}}};
   wire        in_ctr = host_req.addr >= pio_pkg::CTR0_OFF && host_req.addr <= pio_pkg::CTR2_OFF;
   wire [2:0]  rd_exp = (HAS_COUNTER && rd_p && in_ctr) ?
                        3'h1 << (host_req.addr - pio_pkg::CTR0_OFF) : 3'h0;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_wr_p(logic [7:0] off);
      wr_p && host_req.addr == off;
   endsequence
   sequence s_rd_out_a;
      rd_p && !host_req.wr && host_req.addr == pio_pkg::PORT_A_OFF && line_oe.a == 8'hFF;
   endsequence

   property p_rvalid;
      rd_any |=> host_rvalid;
   endproperty
   property p_no_rvalid;
      !rd_any |=> !host_rvalid;
   endproperty
   property p_wr_a;
      s_wr_p(pio_pkg::PORT_A_OFF) |=> line_out.a == $past(host_req.wdata[7:0]);
   endproperty
   property p_hold_b;
      !(wr_p && host_req.addr == pio_pkg::PORT_B_OFF) |=> $stable(line_out.b);
   endproperty
   property p_cfg;
      s_wr_p(pio_pkg::PORT_CFG_OFF) ##0 cfg_ok |=> line_oe == $past(oe_new);
   endproperty
   property p_cfg_bad;
      s_wr_p(pio_pkg::PORT_CFG_OFF) ##0 !cfg_ok |=> $stable(line_oe);
   endproperty
   property p_rd_out;
      s_rd_out_a |=> host_rdata == {24'h000000, $past(line_out.a)};
   endproperty
   property p_irq_off;
      wr_c && host_req.addr == pio_pkg::IRQ_REG_OFF && !(host_req.wdata[0] && host_req.wdata[6])
         |=> ##1 host_irq == !$past(host_req.wdata[1], 2);
   endproperty
   property p_osc;
      HAS_COUNTER && wr_c && host_req.addr == pio_pkg::USER_REG_OFF
         |=> osc_freq_select == $past(host_req.wdata[2]);
   endproperty
   property p_ctr_rd;
      ctr_rd == rd_exp;
   endproperty
   property p_ctr_ld;
      s_wr_p(pio_pkg::CTR1_OFF) |=> HAS_COUNTER ?
         (ctr_wr.load == 3'h2 && ctr_wr.data == $past(host_req.wdata[7:0])) :
         ctr_wr.load == 3'h0;
   endproperty
   property p_no_ld;
      !wr_p |=> ctr_wr.load == 3'h0 && !ctr_wr.ctrl_wr;
   endproperty

   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   a_no_rvalid: assert property (p_no_rvalid) else $error("spurious rvalid");
   a_wr_a: assert property (p_wr_a) else $error("port A latch wrong");
   a_hold_b: assert property (p_hold_b) else $error("port B latch moved");
   a_cfg: assert property (p_cfg) else $error("direction wrong");
   a_cfg_bad: assert property (p_cfg_bad) else $error("bad config taken");
   a_rd_out: assert property (p_rd_out) else $error("output readback wrong");
   a_irq_off: assert property (p_irq_off) else $error("irq level wrong");
   a_osc: assert property (p_osc) else $error("osc select wrong");
   a_ctr_rd: assert property (p_ctr_rd) else $error("counter read strobe wrong");
   a_ctr_ld: assert property (p_ctr_ld) else $error("counter load wrong");
   a_no_ld: assert property (p_no_ld) else $error("spurious counter strobe");
endmodule

bind pio_regs pio_regs_chk #(.HAS_COUNTER(HAS_COUNTER)) u_chk (
   .clock(clock), .rst_n(rst_n), .host_req(host_req), .host_rdata(host_rdata),
   .host_rvalid(host_rvalid), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
   .irq_source_in(irq_source_in), .host_irq(host_irq), .ctr_wr(ctr_wr), .ctr_rd(ctr_rd),
   .ctr_rdata(ctr_rdata), .osc_freq_select(osc_freq_select));

`default_nettype wire

// >>> testbench/pio_ext_model.sv
// Far-side model: external sources sharing the port pins, and a counter data source.
`timescale 1ns/1ps
`default_nettype none

module pio_ext_model (
   input  wire logic                clock,
   input  wire pio_pkg::pio_lines_t ext_drive,
   input  wire pio_pkg::pio_lines_t line_out,
   input  wire pio_pkg::pio_lines_t line_oe,
   input  wire logic [2:0]          ctr_rd,
   output var  pio_pkg::pio_lines_t line_in,
   output var  logic [7:0]          ctr_rdata
);
   logic [7:0] idle_reg = 8'h5A;

   // Each pin resolves to the board driver where enabled, else to the outside source.
   assign line_in = pio_pkg::pio_lines_t'((line_out & line_oe) | (ext_drive & ~line_oe));
   assign ctr_rdata = (ctr_rd == 3'h1) ? 8'hA1 : (ctr_rd == 3'h2) ? 8'hB2 :
                      (ctr_rd == 3'h4) ? 8'hC3 : idle_reg;

   // The data bus wanders between reads, so a stale capture cannot pass for a real one.
   always_ff @(posedge clock)
      idle_reg <= idle_reg + 8'h35;
endmodule

`default_nettype wire

// >>> testbench/pio_regs_tb.sv
// Self-checking bench for the parallel I/O register block.
`timescale 1ns/1ps
`default_nettype none

module pio_regs_tb;
   logic                   clock;
   logic                   rst_n;
   pio_pkg::pio_host_req_t req;
   logic [31:0]            rdata;
   logic                   rvalid;
   pio_pkg::pio_lines_t    lin, lout, loe, ext;
   logic                   irq_src, irq, osc;
   pio_pkg::pio_ctr_wr_t   ctr_wr;
   logic [2:0]             ctr_rd;
   logic [7:0]             ctr_rdata, cfg;
   int                     mismatches, comparisons;
   logic [31:0]            seed, rd_val, exp_w;
   logic [23:0]            lat;
   logic [31:0]            rdata_b;
   logic                   osc_b;

   pio_regs #(.HAS_COUNTER(1'b1)) dut (.clock(clock), .rst_n(rst_n), .host_req(req),
      .host_rdata(rdata), .host_rvalid(rvalid), .line_in(lin), .line_out(lout),
      .line_oe(loe), .irq_source_in(irq_src), .host_irq(irq), .ctr_wr(ctr_wr),
      .ctr_rd(ctr_rd), .ctr_rdata(ctr_rdata), .osc_freq_select(osc));
   pio_ext_model u_ext (.clock(clock), .ext_drive(ext), .line_out(lout), .line_oe(loe),
      .ctr_rd(ctr_rd), .line_in(lin), .ctr_rdata(ctr_rdata));
   // The basic variant shares the bus and must leave the counter locations unmapped.
   pio_regs #(.HAS_COUNTER(1'b0)) dut_basic (.clock(clock), .rst_n(rst_n), .host_req(req),
      .host_rdata(rdata_b), .host_rvalid(), .line_in(lin), .line_out(), .line_oe(),
      .irq_source_in(irq_src), .host_irq(), .ctr_wr(), .ctr_rd(), .ctr_rdata(ctr_rdata),
      .osc_freq_select(osc_b));

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
   endfunction
   function automatic logic [23:0] out_mask(input logic [7:0] c);
      return {{8{~c[4]}}, {8{~c[1]}}, {4{~c[3]}}, {4{~c[0]}}};
   endfunction
   function automatic logic [7:0] port_exp(input logic [7:0] c, input logic [23:0] l, e,
                                           input int k);
      logic [23:0] v;
      v = (l & out_mask(c)) | (e & ~out_mask(c));
      return v[23-8*k -: 8];
   endfunction

   task automatic check(input string name, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic host_wr(input logic ctrl, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      req <= '{sel_ctrl: ctrl, sel_port: !ctrl, rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clock);
      req <= '0;
   endtask
   task automatic host_rd(input logic ctrl, input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      req <= '{sel_ctrl: ctrl, sel_port: !ctrl, rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
      @(posedge clock);
      req <= '0;
      @(negedge clock);
      check("rvalid", {31'h0, rvalid}, 32'h1);
      d = rdata;
   endtask
   task automatic test_done();
      if (mismatches == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      mismatches++;
      test_done();
   end

   initial
   begin
      rst_n = 1'b0;
      req = '0;
      ext = '0;
      irq_src = 1'b0;
      seed = 32'hC5AF4B84;
      mismatches = 0;
      comparisons = 0;
      lat = '0;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      check("oe_reset", {8'h0, loe}, 32'h0);
      check("irq_reset", {31'h0, irq}, 32'h1);
      host_rd(1'b1, pio_pkg::IRQ_REG_OFF, rd_val);
      check("irq_reg", rd_val & 32'h47, 32'h41);
      host_rd(1'b0, pio_pkg::PORT_CFG_OFF, rd_val);
      check("cfg_reset", rd_val, 32'h9B);
      // Data goes in before each direction change, so bytes written while input must surface.
      for (int i = 0; i < 16; i++)
      begin
         cfg = {3'h4, i[3], i[2], 1'b0, i[1], i[0]};
         for (int k = 0; k < 3; k++)
         begin
            seed = lfsr(seed);
            lat[23-8*k -: 8] = seed[7:0];
            host_wr(1'b0, k[7:0], {24'h0, seed[7:0]});
         end
         host_wr(1'b0, pio_pkg::PORT_CFG_OFF, {24'h0, cfg});
         seed = lfsr(seed);
         ext <= seed[23:0];
         repeat (6) @(posedge clock);
         @(negedge clock);
         check("oe", {8'h0, loe}, {8'h0, out_mask(cfg)});
         check("lines", {8'h0, lout & loe}, {8'h0, lat & out_mask(cfg)});
         for (int k = 0; k < 3; k++)
         begin
            host_rd(1'b0, k[7:0], rd_val);
            check("port", rd_val, {24'h0, port_exp(cfg, lat, ext, k)});
         end
      end
      // Bit 0 of port C is set; the other seven are read back from the input pins and written into the latch.
      host_rd(1'b0, pio_pkg::PORT_C_OFF, rd_val);
      host_wr(1'b0, pio_pkg::PORT_C_OFF, {24'h0, rd_val[7:1], 1'b1});
      @(negedge clock);
      check("merge", {24'h0, lout.c}, {24'h0, ext.c[7:1], 1'b1});
      host_wr(1'b0, pio_pkg::PORT_CFG_OFF, 32'h00000000);
      host_wr(1'b0, pio_pkg::PORT_CFG_OFF, 32'h000000E0);
      host_rd(1'b0, pio_pkg::PORT_CFG_OFF, rd_val);
      check("cfg_refused", rd_val, 32'h9B);
      host_rd(1'b0, 8'h08, rd_val);
      check("unmapped", rd_val, 32'h0);
      for (int i = 0; i < 16; i++)
      begin
         host_rd(1'b1, pio_pkg::IRQ_REG_OFF, rd_val);
         exp_w = (rd_val & ~32'h47) | {25'h0, i[2], 3'h0, 1'b1, i[1], i[0]};
         host_wr(1'b1, pio_pkg::IRQ_REG_OFF, exp_w);
         irq_src <= i[3];
         repeat (6) @(posedge clock);
         @(negedge clock);
         check("host_irq", {31'h0, irq}, {31'h0, (i[3] & i[0] & i[2]) ? i[1] : ~i[1]});
         host_rd(1'b1, pio_pkg::IRQ_REG_OFF, rd_val);
         check("irq_bits", rd_val & 32'h47, (exp_w & 32'h43) | {29'h0, i[3], 2'h0});
      end
      for (int i = 1; i >= 0; i--)
      begin
         host_rd(1'b1, pio_pkg::USER_REG_OFF, rd_val);
         exp_w = {rd_val[31:3], i[0], 2'h2};
         host_wr(1'b1, pio_pkg::USER_REG_OFF, exp_w);
         @(negedge clock);
         check("osc", {31'h0, osc}, {31'h0, i[0]});
         check("osc_basic", {31'h0, osc_b}, 32'h0);
         host_rd(1'b1, pio_pkg::USER_REG_OFF, rd_val);
         check("user_reg", rd_val, exp_w);
         check("user_basic", rdata_b, 32'h0);
      end
      for (int k = 4; k < 8; k++)
      begin
         seed = lfsr(seed);
         host_wr(1'b0, k[7:0], {24'h0, seed[7:0]});
         @(negedge clock);
         check("ctr_wr", {20'h0, ctr_wr},
               {20'h0, (k == 7) ? 3'h0 : 3'h1 << (k - 4), k == 7, seed[7:0]});
         host_rd(1'b0, k[7:0], rd_val);
         check("ctr_data", rd_val, (k == 7) ? 32'h0 : 32'hA1 + (k - 4) * 32'h11);
         check("ctr_basic", rdata_b, 32'h0);
      end
      test_done();
   end
endmodule

`default_nettype wire
